/* File: common/tdro_link_if.sv */
// Register access link between the host controller and the device.
// Both ends run on the same pclk; the bench supplies it.
`timescale 1ns/1ps
`default_nettype none
interface tdro_link_if;
   logic       req;    // Host request, held until ack.
   logic       we;     // High for a write.
   logic [7:0] addr;   // Register address.
   logic [7:0] wdata;  // Write data.
   logic       ack;    // Device one-cycle answer.
   logic [7:0] rdata;  // Read data, valid with ack.
   modport dev  (input req, we, addr, wdata, output ack, rdata);
   modport host (output req, we, addr, wdata, input ack, rdata);
endinterface : tdro_link_if
`default_nettype wire

/* File: common/tdro_pkg.sv */
// Constants shared by both ends of the override register link.
// Assumes a single 20 MHz clock on both ends.
package tdro_pkg;
   localparam logic [7:0] ADDR_SENS_HI   = 8'h00;
   localparam logic [7:0] ADDR_SENS_LO   = 8'h01;
   localparam logic [7:0] ADDR_CONV0_HI  = 8'h02;
   localparam logic [7:0] ADDR_CONV0_LO  = 8'h03;
   localparam logic [7:0] ADDR_CONV1_HI  = 8'h04;
   localparam logic [7:0] ADDR_CONV1_LO  = 8'h05;
   localparam logic [7:0] ADDR_STATUS    = 8'h07;
   localparam logic [7:0] ADDR_OVR_SEL   = 8'h08;
   localparam logic [7:0] ADDR_SOVR_HI   = 8'h09;
   localparam logic [7:0] ADDR_SOVR_LO   = 8'h0a;
   localparam logic [7:0] ADDR_C0OVR_HI  = 8'h0b;
   localparam logic [7:0] ADDR_C0OVR_LO  = 8'h0c;
   localparam logic [7:0] ADDR_C1OVR_HI  = 8'h0d;
   localparam logic [7:0] ADDR_C1OVR_LO  = 8'h0e;
   localparam logic [7:0] ADDR_ACCESS    = 8'h11;
   localparam logic [7:0] PSWD_FIRST     = 8'hcd;
   localparam logic [7:0] PSWD_TOP       = 8'hf0;
   localparam logic [7:0] PSWD_MID       = 8'hef;
   localparam logic [1:0] LEVEL_BASE     = 2'h0;
   localparam logic [1:0] LEVEL_MID      = 2'h1;
   localparam logic [1:0] LEVEL_TOP      = 2'h3;
   localparam int         SEL_TEMP_BIT   = 0;
   localparam int         SEL_CONV_BIT   = 1;
   localparam logic [7:0] STATUS_BUSY    = 8'h01;
   localparam logic [7:0] STATUS_READY   = 8'h00;
   localparam logic [7:0] BYTE_ZERO      = 8'h00;
   localparam logic [11:0] WORD_ZERO     = 12'h000;
   localparam longint     CLK_PERIOD_NS  = 50;
   localparam longint     SAMPLE_NS      = 25000000;
   localparam longint     READY_MAX_NS   = 100000000;
   localparam int SAMPLE_CYCLES = int'((SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int READY_CYCLES  = int'(READY_MAX_NS / CLK_PERIOD_NS);
   // Host APB map.
   localparam logic [11:0] APB_CMD       = 12'h000;
   localparam logic [11:0] APB_STATUS    = 12'h004;
   localparam int         CMD_ADDR_LSB   = 0;
   localparam int         CMD_DATA_LSB   = 8;
   localparam int         CMD_WRITE_BIT  = 16;
   localparam int         STAT_BUSY_BIT  = 0;
   localparam int         STAT_DONE_BIT  = 1;
   localparam int         STAT_DATA_LSB  = 8;
   localparam logic [31:0] WORD32_ZERO   = 32'h0000_0000;
endpackage : tdro_pkg

/* File: test/tb.sv */
// Testbench: software side over APB, sensor and converter words driven directly.
// Both ends meet in one link interface; the checker watches it.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int SC = 8;
   localparam int RC = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, spulse, e;
   logic [11:0] paddr, sens, c0, c1, tix, cv0, cv1, os, o0, o1;
   logic [11:0] ov[3];
   logic [31:0] pwdata, prdata, r;
   logic [7:0]  exp_q[$];
   int          n_fail, n_compared, cyc, gap;
   tdro_link_if link ();
   tdro_device #(.SAMPLE_CYCLES(SC), .READY_CYCLES(RC)) u_tdro_device (.pclk(pclk), .presetn(presetn),
      .link(link), .sensor_word(sens), .comp0_word(c0), .comp1_word(c1), .sample_pulse(spulse),
      .table_index(tix), .conv0_input(cv0), .conv1_input(cv1));
   tdro_host u_tdro_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   tdro_link_chk #(.READY_CYCLES(RC)) u_tdro_link_chk (.pclk(pclk), .presetn(presetn), .req(link.req),
      .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      n_compared++;
      if (seen !== ex) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, ex, seen);
      end
   endtask : chk
   task end_of_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One device transfer: command, then poll until the sticky done bit shows.
   task op(input logic w, input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, tdro_pkg::APB_CMD, {15'h0, w, d, a});
      do apb(1'b0, tdro_pkg::APB_STATUS, 32'h0); while (r[tdro_pkg::STAT_DONE_BIT] !== 1'b1);
   endtask : op
   task rd(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      op(1'b0, a, 8'h00);
      chk("status data", {24'h0, r[tdro_pkg::STAT_DATA_LSB +: 8]}, {24'h0, x});
   endtask : rd
   // Every device read is matched in order against the oldest expectation.
   always @(posedge pclk) begin
      if (link.ack === 1'b1 && link.we === 1'b0) begin
         if (exp_q.size() == 0) chk("unexpected read", 32'h1, 32'h0);
         else chk("link read", {24'h0, link.rdata}, {24'h0, exp_q.pop_front()});
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         end_of_test();
      end
      if (spulse === 1'b1) begin
         if (gap > 0) chk("sample gap", gap, SC);
         gap = 1;
      end else if (gap > 0) gap++;
   end
   initial begin
      void'($urandom(32'hedb87c97));
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      sens = 12'($urandom);
      c0 = 12'($urandom);
      c1 = 12'($urandom);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(tdro_pkg::ADDR_STATUS, tdro_pkg::STATUS_BUSY);
      rd(tdro_pkg::ADDR_SENS_LO, 8'h00);
      for (int i = 8; i <= 14; i++) rd(8'(i), 8'h00);
      rd(8'h06, 8'h00);
      apb(1'b0, 12'h008, 32'h0);
      chk("apb unmapped", e, 1'b1);
      rd(tdro_pkg::ADDR_STATUS, tdro_pkg::STATUS_READY);
      op(1'b1, tdro_pkg::ADDR_ACCESS, tdro_pkg::PSWD_FIRST);
      op(1'b1, tdro_pkg::ADDR_ACCESS, tdro_pkg::PSWD_MID);
      op(1'b1, tdro_pkg::ADDR_OVR_SEL, 8'h01);
      op(1'b1, tdro_pkg::ADDR_C0OVR_LO, 8'h44);
      rd(tdro_pkg::ADDR_OVR_SEL, 8'h00);
      rd(tdro_pkg::ADDR_C0OVR_LO, 8'h00);
      op(1'b1, tdro_pkg::ADDR_ACCESS, tdro_pkg::PSWD_FIRST);
      op(1'b1, tdro_pkg::ADDR_ACCESS, tdro_pkg::PSWD_TOP);
      rd(tdro_pkg::ADDR_ACCESS, {6'h00, tdro_pkg::LEVEL_TOP});
      for (int k = 0; k < 3; k++) begin
         ov[k] = 12'($urandom);
         op(1'b1, 8'h09 + 8'(2 * k), {4'hf, ov[k][11:8]});
         rd(8'h09 + 8'(2 * k), 8'h00);
         op(1'b1, 8'h0a + 8'(2 * k), ov[k][7:0]);
         rd(8'h09 + 8'(2 * k), {4'h0, ov[k][11:8]});
         rd(8'h0a + 8'(2 * k), ov[k][7:0]);
      end
      for (int m = 1; m <= 3; m++) begin
         op(1'b1, tdro_pkg::ADDR_OVR_SEL, 8'(m % 3));
         rd(tdro_pkg::ADDR_OVR_SEL, 8'(m % 3));
         repeat (4) @(posedge pclk);
         chk("table index", tix, m == 1 ? ov[0] : sens);
         chk("conv0 input", cv0, m == 2 ? ov[1] : c0);
         chk("conv1 input", cv1, m == 2 ? ov[2] : c1);
      end
      for (int j = 0; j < 2; j++) begin
         sens <= 12'($urandom);
         c0   <= 12'($urandom);
         c1   <= 12'($urandom);
         repeat (2 * SC + 4) @(posedge pclk);
         {os, o0, o1} = {sens, c0, c1};
         rd(tdro_pkg::ADDR_SENS_HI, {4'h0, os[11:8]});
         sens <= ~os;
         c0   <= ~o0;
         c1   <= ~o1;
         if (j == 0) rd(tdro_pkg::ADDR_SENS_LO, os[7:0]);
         if (j == 0) rd(tdro_pkg::ADDR_SENS_LO, os[7:0]);
         rd(tdro_pkg::ADDR_CONV0_HI, {4'h0, o0[11:8]});
         rd(tdro_pkg::ADDR_CONV0_LO, o0[7:0]);
         rd(tdro_pkg::ADDR_CONV1_HI, {4'h0, o1[11:8]});
         rd(tdro_pkg::ADDR_CONV1_LO, o1[7:0]);
      end
      repeat (4) @(posedge pclk);
      chk("pending reads", exp_q.size(), 32'h0);
      end_of_test();
   end
endmodule : tb
`default_nettype wire

/* File: test/tdro_link_chk.sv */
// Checker for the register link: read-back values against the writes seen.
// Instantiated in tb beside the link interface; sees plain link wires only.
`timescale 1ns/1ps
`default_nettype none
module tdro_link_chk #(
   parameter int READY_CYCLES = 20
) (
   input wire logic       pclk,    // Clock.
   input wire logic       presetn, // Reset, low.
   input wire logic       req,     // Request.
   input wire logic       we,      // Write.
   input wire logic [7:0] addr,    // Address.
   input wire logic [7:0] wdata,   // Write data.
   input wire logic       ack,     // Answer.
   input wire logic [7:0] rdata    // Read data.
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       armed_q;
   logic [1:0] lvl_q;
   logic [1:0] sel_q;
   logic       snap_q;
   logic       lov_q;
   logic [7:0] lo_q;
   int         up_q;
   wire logic  wr = ack && we;
   wire logic  rd = ack && !we;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_q <= 0;
      end else if (up_q <= READY_CYCLES) begin
         up_q <= up_q + 1;
      end
   end
   // The level is tracked here so that refused select writes can be told apart.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
         lvl_q   <= tdro_pkg::LEVEL_BASE;
      end else if (wr && addr == tdro_pkg::ADDR_ACCESS) begin
         armed_q <= wdata == tdro_pkg::PSWD_FIRST;
         if (wdata != tdro_pkg::PSWD_FIRST) begin
            lvl_q <= armed_q && wdata == tdro_pkg::PSWD_TOP ? tdro_pkg::LEVEL_TOP :
                     armed_q && wdata == tdro_pkg::PSWD_MID ? tdro_pkg::LEVEL_MID : tdro_pkg::LEVEL_BASE;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= 2'h0;
      end else if (wr && addr == tdro_pkg::ADDR_OVR_SEL && lvl_q == tdro_pkg::LEVEL_TOP) begin
         sel_q <= wdata[1:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_q <= 1'b0;
         lov_q  <= 1'b0;
         lo_q   <= 8'h00;
      end else if (rd && addr == tdro_pkg::ADDR_SENS_HI) begin
         snap_q <= 1'b1;
         lov_q  <= 1'b0;
      end else if (rd && addr == tdro_pkg::ADDR_SENS_LO) begin
         lov_q <= 1'b1;
         lo_q  <= rdata;
      end
   end
   sequence rd_of(logic [7:0] a);
      rd && addr == a;
   endsequence
   ack_once_a: assert property ($rose(req) |=> ack ##1 !ack)
      else $error("link ack not a single cycle after request");
   sens_hi_zero_a: assert property (rd_of(tdro_pkg::ADDR_SENS_HI) |-> rdata[6:5] == 2'b00)
      else $error("sensor high bits 6:5 not zero");
   sens_hi_nib_a: assert property (rd_of(tdro_pkg::ADDR_SENS_HI) |-> rdata[7:4] == 4'h0)
      else $error("sensor high upper nibble not zero");
   conv_hi_zero_a: assert property (rd && addr inside {8'h02, 8'h04, 8'h09, 8'h0b, 8'h0d} |-> rdata[7:4] == 4'h0)
      else $error("high register bits 7:4 not zero");
   sel_value_a: assert property (rd_of(tdro_pkg::ADDR_OVR_SEL) |-> rdata == {6'h00, sel_q})
      else $error("override select read back wrong");
   access_level_a: assert property (rd_of(tdro_pkg::ADDR_ACCESS) |-> rdata == {6'h00, lvl_q})
      else $error("access level read back wrong");
   // Read data shows the status one edge before ack, hence the one extra cycle of grace.
   status_clear_a: assert property (rd_of(tdro_pkg::ADDR_STATUS) |-> up_q <= READY_CYCLES || rdata == 8'h00)
      else $error("sensor status not cleared in time");
   snap_none_a: assert property (rd && addr inside {[8'h01:8'h05]} && !snap_q |-> rdata == 8'h00)
      else $error("snapshot bytes nonzero before first snapshot");
   snap_stable_a: assert property (rd_of(tdro_pkg::ADDR_SENS_LO) ##0 lov_q |-> rdata == lo_q)
      else $error("sensor low byte changed without a new snapshot");
endmodule : tdro_link_chk
`default_nettype wire

/* File: verilog/tdro_device.sv */
// Register bank of the temperature compensated dual converter.
// Assumes the host keeps each request steady until ack and obeys the read order.
// Summary of operation
// - Override data and select cleared at reset.
// - Sensor word split high nibble, low byte.
// - Sensor result refreshed every 25 ms.
// - High-then-low sensor reads give one sample.
// - Host reads sensor, converter0, converter1 in order.
// - Skipping sensor low keeps converter coherency.
// - Converter results feed inputs unless overridden.
// - Converter and override high bits 7:4 zero.
// - Sensor high bits 6:5 read zero.
// - Status cleared within 100 ms of reset.
// - Status zero means sensor output valid.
// - Select bit 0 indexes table with override.
// - Select bit 1 drives converters from overrides.
// - Host writes select only 0, 1 or 2.
// - Host writes reserved select bits as zero.
// - Override writes need top access level.
// - Override high nibble pends until low write.
`timescale 1ns/1ps
`default_nettype none
module tdro_device #(
   parameter int SAMPLE_CYCLES = tdro_pkg::SAMPLE_CYCLES,
   parameter int READY_CYCLES  = tdro_pkg::READY_CYCLES
) (
   input  wire logic        pclk,          // Clock.
   input  wire logic        presetn,       // Asynchronous reset, low.
   tdro_link_if.dev         link,          // Register link.
   input  wire logic [11:0] sensor_word,   // Sensor conversion output.
   input  wire logic [11:0] comp0_word,    // Converter0 arithmetic result.
   input  wire logic [11:0] comp1_word,    // Converter1 arithmetic result.
   output logic             sample_pulse,  // Sensor result taken this cycle.
   output logic [11:0]      table_index,   // Temperature feeding the table.
   output logic [11:0]      conv0_input,   // Converter0 input word.
   output logic [11:0]      conv1_input    // Converter1 input word.
);
   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] sample_cnt_q;
   logic [31:0] ready_cnt_q;
   logic [11:0] sensor_q;
   logic [11:0] comp0_q;
   logic [11:0] comp1_q;
   logic [7:0]  status_q;
   logic [7:0]  snap_sens_lo_q;
   logic [7:0]  snap_c0_hi_q;
   logic [7:0]  snap_c0_lo_q;
   logic [7:0]  snap_c1_hi_q;
   logic [7:0]  snap_c1_lo_q;
   logic [1:0]  sel_q;
   logic [1:0]  level_q;
   logic        pswd_armed_q;
   logic [3:0]  pend_s_q;
   logic [3:0]  pend_c0_q;
   logic [3:0]  pend_c1_q;
   logic [11:0] sovr_q;
   logic [11:0] c0ovr_q;
   logic [11:0] c1ovr_q;
   logic        ack_q;
   logic [7:0]  rdata_q;
   logic        take;
   logic        wr;
   logic        rd;
   logic        top_wr;

   assign take   = link.req && !ack_q;
   assign wr     = take && link.we;
   assign rd     = take && !link.we;
   assign top_wr = wr && (level_q == tdro_pkg::LEVEL_TOP);

   assign link.ack   = ack_q;
   assign link.rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Sensor sampling and start-up status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_cnt_q <= 32'h0000_0000;
         sample_pulse <= 1'b0;
         sensor_q     <= tdro_pkg::WORD_ZERO;
      end else begin
         sample_pulse <= 1'b0;
         if (sample_cnt_q == 32'(SAMPLE_CYCLES - 1)) begin
            sample_cnt_q <= 32'h0000_0000;
            sample_pulse <= 1'b1;
            sensor_q     <= sensor_word;
         end else begin
            sample_cnt_q <= sample_cnt_q + 32'h0000_0001;
         end
      end
   end

   // The result only counts as valid once the first sample is in; READY_CYCLES is
   // not tied to SAMPLE_CYCLES, and by default spans four sample periods.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_cnt_q <= 32'h0000_0000;
         status_q    <= tdro_pkg::STATUS_BUSY;
      end else if (ready_cnt_q != 32'(READY_CYCLES - 1)) begin
         ready_cnt_q <= ready_cnt_q + 32'h0000_0001;
      end else begin
         status_q <= tdro_pkg::STATUS_READY;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comp0_q <= tdro_pkg::WORD_ZERO;
         comp1_q <= tdro_pkg::WORD_ZERO;
      end else begin
         comp0_q <= comp0_word;
         comp1_q <= comp1_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Snapshot taken on the sensor high read; later reads return it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_sens_lo_q <= tdro_pkg::BYTE_ZERO;
         snap_c0_hi_q   <= tdro_pkg::BYTE_ZERO;
         snap_c0_lo_q   <= tdro_pkg::BYTE_ZERO;
         snap_c1_hi_q   <= tdro_pkg::BYTE_ZERO;
         snap_c1_lo_q   <= tdro_pkg::BYTE_ZERO;
      end else if (rd && link.addr == tdro_pkg::ADDR_SENS_HI) begin
         snap_sens_lo_q <= sensor_q[7:0];
         snap_c0_hi_q   <= {4'h0, comp0_q[11:8]};
         snap_c0_lo_q   <= comp0_q[7:0];
         snap_c1_hi_q   <= {4'h0, comp1_q[11:8]};
         snap_c1_lo_q   <= comp1_q[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-byte password; any other access register write drops back.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q      <= tdro_pkg::LEVEL_BASE;
         pswd_armed_q <= 1'b0;
      end else if (wr && link.addr == tdro_pkg::ADDR_ACCESS) begin
         pswd_armed_q <= (link.wdata == tdro_pkg::PSWD_FIRST);
         if (pswd_armed_q && link.wdata == tdro_pkg::PSWD_TOP) begin
            level_q <= tdro_pkg::LEVEL_TOP;
         end else if (pswd_armed_q && link.wdata == tdro_pkg::PSWD_MID) begin
            level_q <= tdro_pkg::LEVEL_MID;
         end else if (link.wdata != tdro_pkg::PSWD_FIRST) begin
            level_q <= tdro_pkg::LEVEL_BASE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Override registers. Only the select field is stored; the host keeps
   // reserved bits and the legal codes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q     <= 2'h0;
         pend_s_q  <= 4'h0;
         pend_c0_q <= 4'h0;
         pend_c1_q <= 4'h0;
         sovr_q    <= tdro_pkg::WORD_ZERO;
         c0ovr_q   <= tdro_pkg::WORD_ZERO;
         c1ovr_q   <= tdro_pkg::WORD_ZERO;
      end else if (top_wr) begin
         case (link.addr)
            tdro_pkg::ADDR_OVR_SEL:  sel_q     <= link.wdata[1:0];
            tdro_pkg::ADDR_SOVR_HI:  pend_s_q  <= link.wdata[3:0];
            tdro_pkg::ADDR_C0OVR_HI: pend_c0_q <= link.wdata[3:0];
            tdro_pkg::ADDR_C1OVR_HI: pend_c1_q <= link.wdata[3:0];
            tdro_pkg::ADDR_SOVR_LO:  sovr_q    <= {pend_s_q, link.wdata};
            tdro_pkg::ADDR_C0OVR_LO: c0ovr_q   <= {pend_c0_q, link.wdata};
            tdro_pkg::ADDR_C1OVR_LO: c1ovr_q   <= {pend_c1_q, link.wdata};
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_index <= tdro_pkg::WORD_ZERO;
         conv0_input <= tdro_pkg::WORD_ZERO;
         conv1_input <= tdro_pkg::WORD_ZERO;
      end else begin
         table_index <= sel_q[tdro_pkg::SEL_TEMP_BIT] ? sovr_q : sensor_q;
         conv0_input <= sel_q[tdro_pkg::SEL_CONV_BIT] ? c0ovr_q : comp0_q;
         conv1_input <= sel_q[tdro_pkg::SEL_CONV_BIT] ? c1ovr_q : comp1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answer: one cycle after a request is seen. Unmapped reads return zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q   <= 1'b0;
         rdata_q <= tdro_pkg::BYTE_ZERO;
      end else begin
         ack_q <= take;
         if (rd) begin
            case (link.addr)
               tdro_pkg::ADDR_SENS_HI:  rdata_q <= {4'h0, sensor_q[11:8]};
               tdro_pkg::ADDR_SENS_LO:  rdata_q <= snap_sens_lo_q;
               tdro_pkg::ADDR_CONV0_HI: rdata_q <= snap_c0_hi_q;
               tdro_pkg::ADDR_CONV0_LO: rdata_q <= snap_c0_lo_q;
               tdro_pkg::ADDR_CONV1_HI: rdata_q <= snap_c1_hi_q;
               tdro_pkg::ADDR_CONV1_LO: rdata_q <= snap_c1_lo_q;
               tdro_pkg::ADDR_STATUS:   rdata_q <= status_q;
               tdro_pkg::ADDR_OVR_SEL:  rdata_q <= {6'h00, sel_q};
               tdro_pkg::ADDR_SOVR_HI:  rdata_q <= {4'h0, sovr_q[11:8]};
               tdro_pkg::ADDR_SOVR_LO:  rdata_q <= sovr_q[7:0];
               tdro_pkg::ADDR_C0OVR_HI: rdata_q <= {4'h0, c0ovr_q[11:8]};
               tdro_pkg::ADDR_C0OVR_LO: rdata_q <= c0ovr_q[7:0];
               tdro_pkg::ADDR_C1OVR_HI: rdata_q <= {4'h0, c1ovr_q[11:8]};
               tdro_pkg::ADDR_C1OVR_LO: rdata_q <= c1ovr_q[7:0];
               tdro_pkg::ADDR_ACCESS:   rdata_q <= {6'h00, level_q};
               default:                 rdata_q <= tdro_pkg::BYTE_ZERO;
            endcase
         end
      end
   end
endmodule : tdro_device
`default_nettype wire

/* File: verilog/tdro_host.sv */
// Host controller: software issues single register transfers over APB.
// Assumes the device answers every request with a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module tdro_host (
   input  wire logic        pclk,     // Clock.
   input  wire logic        presetn,  // Asynchronous reset, low.
   input  wire logic        psel,     // APB select.
   input  wire logic        penable,  // APB enable.
   input  wire logic        pwrite,   // APB direction.
   input  wire logic [11:0] paddr,    // APB byte address.
   input  wire logic [31:0] pwdata,   // APB write data.
   output logic [31:0]      prdata,   // APB read data.
   output logic             pready,   // APB ready.
   output logic             pslverr,  // APB error, unmapped address.
   tdro_link_if.host        link      // Register link.
);
   typedef enum logic [0:0] {
      HST_IDLE = 1'b0,
      HST_WAIT = 1'b1
   } tdro_state_type;

   tdro_state_type state_q;
   logic           req_q;
   logic           we_q;
   logic [7:0]     addr_q;
   logic [7:0]     wdata_q;
   logic [7:0]     result_q;
   logic           done_q;
   logic           access;
   logic           mapped;
   logic           cmd_wr;
   logic           stat_rd;

   // One wait state keeps every APB output registered.
   assign access  = psel && penable && !pready;
   assign mapped  = (paddr == tdro_pkg::APB_CMD) || (paddr == tdro_pkg::APB_STATUS);
   // A command takes effect only at the edge that completes its transfer.
   assign cmd_wr  = psel && penable && pready && pwrite && (paddr == tdro_pkg::APB_CMD);
   assign stat_rd = access && !pwrite && (paddr == tdro_pkg::APB_STATUS);

   assign link.req   = req_q;
   assign link.we    = we_q;
   assign link.addr  = addr_q;
   assign link.wdata = wdata_q;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= tdro_pkg::WORD32_ZERO;
      end else begin
         pready  <= access;
         pslverr <= access && !mapped;
         if (access && !pwrite) begin
            prdata <= (paddr == tdro_pkg::APB_STATUS) ?
                      {16'h0000, result_q, 6'h00, done_q, (state_q == HST_WAIT)} :
                      tdro_pkg::WORD32_ZERO;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // A command written while busy is dropped; software polls the done bit after each command.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= HST_IDLE;
         req_q    <= 1'b0;
         we_q     <= 1'b0;
         addr_q   <= tdro_pkg::BYTE_ZERO;
         wdata_q  <= tdro_pkg::BYTE_ZERO;
         result_q <= tdro_pkg::BYTE_ZERO;
         done_q   <= 1'b0;
      end else begin
         if (stat_rd) begin
            done_q <= 1'b0;
         end
         case (state_q)
            HST_IDLE: begin
               if (cmd_wr) begin
                  req_q   <= 1'b1;
                  we_q    <= pwdata[tdro_pkg::CMD_WRITE_BIT];
                  addr_q  <= pwdata[tdro_pkg::CMD_ADDR_LSB +: 8];
                  wdata_q <= pwdata[tdro_pkg::CMD_DATA_LSB +: 8];
                  state_q <= HST_WAIT;
               end
            end
            HST_WAIT: begin
               if (link.ack) begin
                  req_q   <= 1'b0;
                  done_q  <= 1'b1;
                  state_q <= HST_IDLE;
                  if (!we_q) begin
                     result_q <= link.rdata;
                  end
               end
            end
            default: begin
               state_q <= HST_IDLE;
               req_q   <= 1'b0;
            end
         endcase
      end
   end
endmodule : tdro_host
`default_nettype wire
